/* src/bus_power_slot_pkg.sv */
// Package with offsets, field positions, reset values and carrier types of the slot and switch register bank.
package bus_power_slot_pkg;
  localparam logic [7:0] OFF_INTERFACE_AVAILABILITY = 8'h00;
  localparam logic [7:0] OFF_BUS_POWER_SWITCH_CTRL = 8'h01;
  localparam logic [7:0] OFF_BROADCAST_DN_SLOT_COUNT = 8'h02;
  localparam logic [7:0] OFF_LOCAL_DN_SLOT_COUNT = 8'h03;

  localparam int POS_PERIPH_IFACE_PRESENT = 0;
  localparam int POS_POWER_SWITCH_ON = 0;
  localparam int POS_SWITCH_DIAG_ENABLE = 3;
  localparam int POS_SWITCH_MODE_LO = 4;
  localparam int POS_HOLD_SYNC_TO_NEXT = 6;
  localparam int POS_DN_SLOT_MASK_ENABLE = 7;
  localparam int SLOT_COUNT_WIDTH = 6;

  localparam logic [7:0] RST_BUS_POWER_SWITCH_CTRL = 8'h00;
  localparam logic [7:0] RST_BROADCAST_DN_SLOT_COUNT = 8'h00;
  localparam logic [7:0] RST_LOCAL_DN_SLOT_COUNT = 8'h00;
  localparam logic [7:0] SWITCH_CTRL_WRITABLE = 8'h79;
  localparam logic [7:0] BROADCAST_WRITABLE = 8'h3f;
  localparam logic [7:0] LOCAL_WRITABLE = 8'hbf;

  localparam logic [1:0] MODE_INT_NEG_EXT_POS = 2'h0;
  localparam logic [1:0] MODE_DN_UNPOWERED = 2'h1;
  localparam logic [1:0] MODE_SUPPLY_DIFFERS = 2'h2;
  localparam logic [1:0] MODE_RESERVED = 2'h3;

  typedef struct packed {
    logic valid;
    logic write;
    logic from_bus;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [SLOT_COUNT_WIDTH-1:0] broadcast_dn_count;
    logic [SLOT_COUNT_WIDTH-1:0] local_dn_count;
    logic dn_slot_mask_enable;
    logic local_slots_added;
  } frame_cfg_t;

  typedef struct packed {
    logic ext_switch_on_positive;
    logic dn_unpowered;
    logic supply_differs;
    logic mode_reserved;
  } switch_mode_t;
endpackage : bus_power_slot_pkg

/* src/bus_power_slot_regs.sv */
// Register bank for interface capability, downstream power switch control and downstream slot counts.
//
// Contract
// - Capability bit 0 reports peripheral interface presence.
// - Switch control writable only over audio bus.
// - Forward sync after switch-on complete, unless held.
// - Hold bit withholds sync from next node.
// - Decode two-bit external switch mode field.
// - Downstream power only while switch enable set.
// - Broadcast count: slots captured and forwarded downstream.
// - Broadcast count ignored when any mask bit set.
// - Slot changes apply only on new structure.
// - Master node never uses broadcast count.
// - Mask enable clear: local slots captured, consumed.
// - Mask enable set: local slots added after passed.
// - Mask enable bit activates downstream slot masks.
`timescale 1ns/1ps
module bus_power_slot_regs (
  input wire logic clk, // System clock, 200 MHz.
  input wire logic rst, // Asynchronous reset, active high.
  input wire bus_power_slot_pkg::reg_req_t reg_req, // Register request from host port or audio bus.
  input wire logic periph_iface_strap, // Pin: peripheral two-wire interface fitted.
  input wire logic is_master, // High when this node is the bus master.
  input wire logic switch_on_done, // Switch-on-complete flag from the switch status logic.
  input wire logic apply_frame_structure, // One-cycle pulse of the new-structure command.
  input wire logic dn_rx_mask_any, // Any bit set in the downstream receive mask registers.
  output logic [7:0] rd_data, // Read data, valid with rd_valid.
  output logic rd_valid, // One-cycle pulse one cycle after a read request.
  output logic power_switch_on, // Drive bus power onto the downstream side.
  output logic switch_diag_enable, // Switch diagnosis mode.
  output bus_power_slot_pkg::switch_mode_t switch_mode, // Decoded external switch mode.
  output logic sync_to_next_en, // Forward synchronization packets to next node.
  output logic dn_slot_masks_active, // Per-slot downstream masks in force.
  output bus_power_slot_pkg::frame_cfg_t active_cfg // Slot structure in force.
);
  logic strap_meta;
  logic strap_sync;
  logic [7:0] switch_ctrl;
  logic [7:0] broadcast_count;
  logic [7:0] local_count;
  logic [7:0] next_rd_data;
  // Decoded requests, one per register that takes writes, plus the read strobe.
  logic rd_req;
  logic wr_switch;
  logic wr_broadcast;
  logic wr_local;

  // True when a request of the given kind targets the given offset.
  function automatic logic reg_hit(input bus_power_slot_pkg::reg_req_t req, input logic is_write,
                                   input logic [7:0] offset);
    reg_hit = req.valid && (req.write == is_write) && (req.addr == offset);
  endfunction : reg_hit

  // One-hot view of the external switch mode field, so the switch logic needs no decoder of its own.
  function automatic bus_power_slot_pkg::switch_mode_t decode_switch_mode(input logic [1:0] mode_field);
    bus_power_slot_pkg::switch_mode_t mode_onehot;
    mode_onehot = '0;
    case (mode_field)
      bus_power_slot_pkg::MODE_INT_NEG_EXT_POS: begin
        mode_onehot.ext_switch_on_positive = 1'b1;
      end
      bus_power_slot_pkg::MODE_DN_UNPOWERED: begin
        mode_onehot.dn_unpowered = 1'b1;
      end
      bus_power_slot_pkg::MODE_SUPPLY_DIFFERS: begin
        mode_onehot.supply_differs = 1'b1;
      end
      default: begin
        mode_onehot.mode_reserved = 1'b1;
      end
    endcase
    return mode_onehot;
  endfunction : decode_switch_mode

  // The pin is asynchronous to clk, so it is resynchronised before the capability bit reads it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strap_meta <= 1'b0;
      strap_sync <= 1'b0;
    end else begin
      strap_meta <= periph_iface_strap;
      strap_sync <= strap_meta;
    end
  end

  // Writes to the capability offset match no register here and are therefore dropped.
  assign rd_req = reg_req.valid && !reg_req.write;
  assign wr_switch = reg_req.from_bus
                     && reg_hit(reg_req, 1'b1, bus_power_slot_pkg::OFF_BUS_POWER_SWITCH_CTRL);

  assign wr_broadcast = reg_hit(reg_req, 1'b1, bus_power_slot_pkg::OFF_BROADCAST_DN_SLOT_COUNT);
  assign wr_local = reg_hit(reg_req, 1'b1, bus_power_slot_pkg::OFF_LOCAL_DN_SLOT_COUNT);

  // Switch control takes writes from the audio bus only; a local host write is dropped silently.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      switch_ctrl <= bus_power_slot_pkg::RST_BUS_POWER_SWITCH_CTRL;
    end else if (wr_switch) begin
      switch_ctrl <= reg_req.wdata & bus_power_slot_pkg::SWITCH_CTRL_WRITABLE;
    end
  end

  // Slot counts are staged here; the shadow copy only changes on the new-structure pulse.
  // Either port may write them, and counts from 33 to 63 are kept as written rather than clamped.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      broadcast_count <= bus_power_slot_pkg::RST_BROADCAST_DN_SLOT_COUNT;
    end else if (wr_broadcast) begin
      broadcast_count <= reg_req.wdata & bus_power_slot_pkg::BROADCAST_WRITABLE;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      local_count <= bus_power_slot_pkg::RST_LOCAL_DN_SLOT_COUNT;
    end else if (wr_local) begin
      local_count <= reg_req.wdata & bus_power_slot_pkg::LOCAL_WRITABLE;
    end
  end

  // Reads return zero for unmapped offsets and reserved bits.
  always_comb begin
    next_rd_data = 8'h00;
    case (reg_req.addr)
      bus_power_slot_pkg::OFF_INTERFACE_AVAILABILITY: begin
        next_rd_data[bus_power_slot_pkg::POS_PERIPH_IFACE_PRESENT] = strap_sync;
      end
      bus_power_slot_pkg::OFF_BUS_POWER_SWITCH_CTRL: begin
        next_rd_data = switch_ctrl;
      end
      bus_power_slot_pkg::OFF_BROADCAST_DN_SLOT_COUNT: begin
        next_rd_data = broadcast_count;
      end
      bus_power_slot_pkg::OFF_LOCAL_DN_SLOT_COUNT: begin
        next_rd_data = local_count;
      end
      default: begin
        next_rd_data = 8'h00;
      end
    endcase
  end

  // The read strobe lasts one cycle; the data holds until the next read so a slow host can pick it up.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_req;
    end
  end

  // Reads are answered for both ports alike.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else if (rd_req) begin
      rd_data <= next_rd_data;
    end
  end

  // Switch outputs follow the register one cycle after a bus write.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      power_switch_on <= 1'b0;
    end else begin
      power_switch_on <= switch_ctrl[bus_power_slot_pkg::POS_POWER_SWITCH_ON];
    end
  end

  // Diagnosis stays on only as long as software leaves the bit set.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      switch_diag_enable <= 1'b0;
    end else begin
      switch_diag_enable <= switch_ctrl[bus_power_slot_pkg::POS_SWITCH_DIAG_ENABLE];
    end
  end

  // Sync waits for switch-on completion, so the next node never sees sync on an unpowered line.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_to_next_en <= 1'b0;
    end else begin
      sync_to_next_en <= switch_ctrl[bus_power_slot_pkg::POS_POWER_SWITCH_ON] && switch_on_done
                         && !switch_ctrl[bus_power_slot_pkg::POS_HOLD_SYNC_TO_NEXT];
    end
  end

  // The reserved mode code gets its own flag so that misprogramming is visible downstream.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      switch_mode <= '0;
    end else begin
      switch_mode <= decode_switch_mode(switch_ctrl[bus_power_slot_pkg::POS_SWITCH_MODE_LO +: 2]);
    end
  end

  // The mask enable acts on the structure in force, so it switches together with the slot counts.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dn_slot_masks_active <= 1'b0;
    end else if (apply_frame_structure) begin
      dn_slot_masks_active <= local_count[bus_power_slot_pkg::POS_DN_SLOT_MASK_ENABLE];
    end
  end

  // The active slot structure lives in its own module so that frame logic sees only applied values.
  frame_struct_shadow u_shadow (
    .clk(clk),
    .rst(rst),
    .apply_frame_structure(apply_frame_structure),
    .is_master(is_master),
    .dn_rx_mask_any(dn_rx_mask_any),
    .staged_broadcast(broadcast_count),
    .staged_local(local_count),
    .active_cfg(active_cfg)
  );
endmodule : bus_power_slot_regs

/* src/frame_struct_shadow.sv */
// Active copy of the downstream slot structure, loaded only when a new frame structure is applied.
`timescale 1ns/1ps
module frame_struct_shadow (
  input wire logic clk, // System clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic apply_frame_structure, // One-cycle pulse: new structure takes effect.
  input wire logic is_master, // High when this node is the bus master.
  input wire logic dn_rx_mask_any, // Any bit set in the four downstream receive mask registers.
  input wire logic [7:0] staged_broadcast, // Broadcast count register as written.
  input wire logic [7:0] staged_local, // Local count register as written.
  output bus_power_slot_pkg::frame_cfg_t active_cfg // Structure in force for the current frames.
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      active_cfg <= '0;
    end else if (apply_frame_structure) begin
      // A master ignores the broadcast count, and receive masks override it in a slave.
      if (is_master || dn_rx_mask_any) begin
        active_cfg.broadcast_dn_count <= '0;
      end else begin
        active_cfg.broadcast_dn_count <= staged_broadcast[bus_power_slot_pkg::SLOT_COUNT_WIDTH-1:0];
      end
      active_cfg.local_dn_count <= staged_local[bus_power_slot_pkg::SLOT_COUNT_WIDTH-1:0];
      active_cfg.dn_slot_mask_enable <= staged_local[bus_power_slot_pkg::POS_DN_SLOT_MASK_ENABLE];
      active_cfg.local_slots_added <= staged_local[bus_power_slot_pkg::POS_DN_SLOT_MASK_ENABLE];
    end
  end
endmodule : frame_struct_shadow

/* tb/bus_power_slot_sva.sv */
// Port checker of the slot and switch register bank.
`timescale 1ns/1ps
module bus_power_slot_chk (
  input wire logic clk, // Clock.
  input wire logic rst, // Reset.
  input wire bus_power_slot_pkg::reg_req_t reg_req, // Request.
  input wire logic is_master, // Master node.
  input wire logic switch_on_done, // Switch done.
  input wire logic apply_frame_structure, // Apply pulse.
  input wire logic dn_rx_mask_any, // Mask bits set.
  input wire logic [7:0] rd_data, // Read data.
  input wire logic rd_valid, // Read strobe.
  input wire logic power_switch_on, // Switch drive.
  input wire bus_power_slot_pkg::switch_mode_t switch_mode, // Mode.
  input wire logic sync_to_next_en, // Sync forward.
  input wire logic dn_slot_masks_active, // Masks on.
  input wire bus_power_slot_pkg::frame_cfg_t active_cfg // Active slots.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire sw_sel = reg_req.valid && reg_req.write && reg_req.addr == bus_power_slot_pkg::OFF_BUS_POWER_SWITCH_CTRL;
  // A second switch write right behind would mask the first one's effect.
  sequence bus_wr;
    sw_sel && reg_req.from_bus ##1 !sw_sel;
  endsequence
  chk_switch_follow: assert property (bus_wr |=> power_switch_on == $past(reg_req.wdata[0], 2))
    else $error("switch drive mismatch");
  chk_local_ignored: assert property (sw_sel && !reg_req.from_bus |=> ##1 $stable(power_switch_on))
    else $error("host write changed switch");
  chk_mode_decode: assert property (bus_wr |=> switch_mode == 4'h8 >> $past(reg_req.wdata[5:4], 2))
    else $error("mode decode mismatch");
  chk_sync_gate: assert property (sync_to_next_en |-> power_switch_on && $past(switch_on_done))
    else $error("sync forwarded early");
  chk_cap_read: assert property (reg_req.valid && !reg_req.write && reg_req.addr == 8'h00
    |=> rd_valid && rd_data[7:1] == 7'h00)
    else $error("capability read wrong");
  chk_slot_hold: assert property (!apply_frame_structure |=> $stable(active_cfg))
    else $error("slots changed without apply");
  chk_master_bcast: assert property (apply_frame_structure && is_master
    |=> active_cfg.broadcast_dn_count == 6'h00)
    else $error("master used broadcast count");
  chk_mask_ignore: assert property (apply_frame_structure && dn_rx_mask_any
    |=> active_cfg.broadcast_dn_count == 6'h00)
    else $error("broadcast count not ignored");
  chk_mask_active: assert property (apply_frame_structure
    |=> dn_slot_masks_active == active_cfg.dn_slot_mask_enable)
    else $error("slot masks state wrong");
endmodule : bus_power_slot_chk
bind bus_power_slot_regs bus_power_slot_chk chk_u (.clk(clk), .rst(rst), .reg_req(reg_req), .is_master(is_master),
  .switch_on_done(switch_on_done), .apply_frame_structure(apply_frame_structure), .dn_rx_mask_any(dn_rx_mask_any),
  .rd_data(rd_data), .rd_valid(rd_valid), .power_switch_on(power_switch_on), .switch_mode(switch_mode),
  .sync_to_next_en(sync_to_next_en), .dn_slot_masks_active(dn_slot_masks_active), .active_cfg(active_cfg));

/* tb/switch_status_model.sv */
// Model of the switch status logic that reports switch-on completion.
`timescale 1ns/1ps
module switch_status_model #(
  parameter int ON_DELAY = 4
) (
  input wire logic clk, // Clock.
  input wire logic rst, // Reset, active high.
  input wire logic power_switch_on, // Switch drive from the bank.
  output logic switch_on_done // Switch-on complete.
);
  logic [3:0] cnt;
  // Completion only follows a switch that is driven on, and drops with it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 4'h0;
      switch_on_done <= 1'b0;
    end else if (!power_switch_on) begin
      cnt <= 4'h0;
      switch_on_done <= 1'b0;
    end else if (cnt == ON_DELAY[3:0]) begin
      switch_on_done <= 1'b1;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule : switch_status_model

/* tb/testbench.sv */
// Self-checking bench of the slot and switch register bank.
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  bus_power_slot_pkg::reg_req_t reg_req = '0;
  // The strap stands for a fitted peripheral interface.
  logic strap = 1'b1;
  logic is_master = 1'b0;
  logic mask_any = 1'b0;
  logic apply = 1'b0;
  logic [7:0] rd_data;
  logic rd_valid, sw_on, diag, sync_en, masks_on, done;
  bus_power_slot_pkg::switch_mode_t mode;
  bus_power_slot_pkg::frame_cfg_t cfg;
  int error_cnt = 0;
  int checks = 0;
  always #2.5 clk = ~clk;
  bus_power_slot_regs dut_u (.clk(clk), .rst(rst), .reg_req(reg_req), .periph_iface_strap(strap),
    .is_master(is_master), .switch_on_done(done), .apply_frame_structure(apply), .dn_rx_mask_any(mask_any),
    .rd_data(rd_data), .rd_valid(rd_valid), .power_switch_on(sw_on), .switch_diag_enable(diag),
    .switch_mode(mode), .sync_to_next_en(sync_en), .dn_slot_masks_active(masks_on), .active_cfg(cfg));
  switch_status_model part_u (.clk(clk), .rst(rst), .power_switch_on(sw_on), .switch_on_done(done));
  task automatic print_verdict;
    $display("checks=%0d errors=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic bus, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) reg_req <= {1'b1, 1'b1, bus, a, d};
    @(negedge clk) reg_req.valid <= 1'b0;
    repeat (2) @(negedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    int n;
    n = 0;
    @(negedge clk) reg_req <= {1'b1, 1'b0, 1'b1, a, 8'h00};
    @(negedge clk) reg_req.valid <= 1'b0;
    while (rd_valid !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    if (n == 4) begin
      error_cnt++;
      print_verdict();
    end else begin
      cmp(rd_data, e);
    end
  endtask : rd
  task automatic pulse;
    @(negedge clk) apply <= 1'b1;
    @(negedge clk) apply <= 1'b0;
    @(negedge clk);
  endtask : pulse
  initial begin
    #100000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    repeat (8) @(negedge clk);
    rst <= 1'b0;
    repeat (3) @(negedge clk);
    cmp({sw_on, diag, sync_en, masks_on, rd_valid, mode}, {5'h00, 4'h8});
    cmp(cfg, 14'h0000);
    rd(8'h00, 8'h01);
    for (int a = 1; a < 5; a++) rd(a[7:0], 8'h00);
    wr(1'b1, 8'h00, 8'hff);
    rd(8'h00, 8'h01);
    strap <= 1'b0;
    repeat (3) @(negedge clk);
    rd(8'h00, 8'h00);
    wr(1'b0, 8'h01, 8'h01);
    rd(8'h01, 8'h00);
    wr(1'b1, 8'h01, 8'hff);
    rd(8'h01, 8'h79);
    cmp(diag, 1'b1);
    for (int m = 0; m < 4; m++) begin
      wr(1'b1, 8'h01, {2'b00, m[1:0], 4'h1});
      cmp(mode, 4'h8 >> m);
    end
    repeat (10) @(negedge clk);
    cmp(sync_en, 1'b1);
    wr(1'b1, 8'h01, 8'h41);
    cmp({sw_on, sync_en}, 2'b10);
    wr(1'b1, 8'h01, 8'h00);
    cmp({sw_on, sync_en}, 2'b00);
    wr(1'b0, 8'h02, 8'h20);
    wr(1'b0, 8'h03, 8'he0);
    rd(8'h03, 8'ha0);
    cmp(cfg, 14'h0000);
    pulse();
    cmp({masks_on, cfg}, {1'b1, 6'h20, 6'h20, 2'b11});
    wr(1'b0, 8'h03, 8'h05);
    pulse();
    cmp({masks_on, cfg}, {1'b0, 6'h20, 6'h05, 2'b00});
    mask_any <= 1'b1;
    pulse();
    cmp(cfg.broadcast_dn_count, 6'h00);
    mask_any <= 1'b0;
    is_master <= 1'b1;
    pulse();
    cmp(cfg.broadcast_dn_count, 6'h00);
    is_master <= 1'b0;
    pulse();
    cmp(cfg.broadcast_dn_count, 6'h20);
    print_verdict();
  end
endmodule : testbench
